/* File: fcd_params.svh */
/*
  Constants of the flash command decoder: command bytes, unlock addresses,
  sector geometry, status bit positions and timing counts.
  Assumes a single 40 MHz system clock; included by the package and the decoder.
*/
`ifndef FCD_PARAMS_SVH
`define FCD_PARAMS_SVH

// ****************************************************************
// Clock and timing
// ****************************************************************
`define FCD_CLK_MHZ              40
`define FCD_PROG_TIME_US         10
`define FCD_PROG_CYCLES          (`FCD_PROG_TIME_US * `FCD_CLK_MHZ)
`define FCD_ERASE_WINDOW_US      80
`define FCD_ERASE_WINDOW_CYCLES  (`FCD_ERASE_WINDOW_US * `FCD_CLK_MHZ)
`define FCD_ERASE_TIME_US        1000
`define FCD_ERASE_CYCLES         (`FCD_ERASE_TIME_US * `FCD_CLK_MHZ)
`define FCD_GAP_TIMEOUT_US       50
`define FCD_GAP_CYCLES           (`FCD_GAP_TIMEOUT_US * `FCD_CLK_MHZ)

// ****************************************************************
// Command bytes and addresses
// ****************************************************************
`define FCD_CMD_UNLOCK1          8'hAA
`define FCD_CMD_UNLOCK2          8'h55
`define FCD_CMD_PROTECT_READ     8'h90
`define FCD_CMD_PROGRAM          8'hA0
`define FCD_CMD_ERASE_SETUP      8'h80
`define FCD_CMD_SECTOR_ERASE     8'h30
`define FCD_CMD_BULK_ERASE       8'h10
`define FCD_CMD_SUSPEND          8'hB0
`define FCD_CMD_RESUME           8'h30
`define FCD_CMD_RESET            8'hF0
`define FCD_CMD_BYPASS           8'h20
`define FCD_CMD_BYPASS_EXIT      8'h00
`define FCD_ADDR_UNLOCK1         12'h555
`define FCD_ADDR_UNLOCK2         12'hAAA
`define FCD_PROT_ADDR_LOW        2'h2

// ****************************************************************
// Geometry and status bits
// ****************************************************************
`define FCD_PRIMARY_SECTORS      8
`define FCD_SECONDARY_SECTORS    4
`define FCD_SECTORS              12
`define FCD_SECTOR_BYTES         16
`define FCD_PRIMARY_MASK         12'h0FF
`define FCD_SECONDARY_MASK       12'hF00
`define FCD_ERASED_BYTE          8'hFF
`define FCD_BIT_POLL             7
`define FCD_BIT_TOGGLE           6
`define FCD_BIT_ERROR            5
`define FCD_BIT_ERASE_TIMEOUT    3

`endif

/* File: fcd_pkg.sv */
/*
  Types of the flash command decoder: decoder states and state records.
  Assumes fcd_params.svh is on the include path.
*/
`include "fcd_params.svh"

package fcd_pkg;

  // ****************************************************************
  // Decoder states
  // ****************************************************************
  typedef enum logic [3:0] {
    ST_READ      = 4'h0,
    ST_UNLK1     = 4'h1,
    ST_UNLK2     = 4'h2,
    ST_PROG_DATA = 4'h3,
    ST_ERS_CMD   = 4'h4,
    ST_ERS_UNLK1 = 4'h5,
    ST_ERS_UNLK2 = 4'h6,
    ST_ERS_WIN   = 4'h7,
    ST_ERASE     = 4'h8,
    ST_PROGRAM   = 4'h9,
    ST_PROT      = 4'hA,
    ST_ERROR     = 4'hB,
    ST_BYPASS    = 4'hC,
    ST_BYP_PROG  = 4'hD,
    ST_BYP_RST   = 4'hE
  } fcd_state_e;

  // ****************************************************************
  // Decoder state record
  // ****************************************************************
  typedef struct packed {
    fcd_state_e  state;
    logic        susp;
    logic        bypass;
    logic        err;
    logic        eto;
    logic        bulk;
    logic        toggle;
    logic        array_sel;
    logic [15:0] wr_addr;
    logic [7:0]  prog_idx;
    logic [7:0]  prog_data;
    logic [11:0] erase_mask;
    logic        wr_q;
    logic        rd_q;
    logic [7:0]  data_out;
    logic        data_oe;
    logic        ready_busy;
  } fcd_regs_s;

  // Timer state record
  typedef struct packed {
    logic [15:0] count;
    logic        expired;
  } fcd_timer_s;

endpackage

/* File: fcd_timer.sv */
/*
  Down-counting interval timer with load, freeze and a one-cycle expiry
  pulse. Assumes load values of at least one; a load of zero cancels it.
*/
`timescale 1ns/10ps

module fcd_timer
  import fcd_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        reset,
  input  wire logic        load,
  input  wire logic        hold,
  input  wire logic [15:0] load_value,
  output logic             expired
);

  fcd_timer_s t;
  fcd_timer_s next_t;

  // ****************************************************************
  // Counter
  // ****************************************************************
  // Load wins over counting so a restart never sees a stale expiry
  always_comb begin
    next_t = t;
    next_t.expired = 1'b0;
    if (load) begin
      next_t.count = load_value;
    end else if (!hold && t.count != 16'h0) begin
      next_t.count = t.count - 16'h1;
      next_t.expired = (t.count == 16'h1);
    end
  end

  // State register
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      t <= '0;
    end else begin
      t <= next_t;
    end
  end

  assign expired = t.expired;

endmodule

/* File: fcd_decoder.sv */
/*
  Flash command decoder with embedded program and erase sequencer for a
  primary array of eight sectors and a secondary array of four.
  Assumes bus strobes and sector selects are synchronous to clk and that
  sector selects come from an outside address decoder.
*/
`timescale 1ns/10ps
`include "fcd_params.svh"

// Summary of operation
// - Eight primary and four secondary sectors, each protectable alone.
// - Erase per sector; erase may be suspended for reads, then resumed.
// - Ready/busy low during program or erase, high otherwise.
// - Any primary select routes to primary, a secondary select alone to secondary.
// - Bytes decoded as they come; execute only on full, timely sequence.
// - Bad byte or gap timeout abandons sequence, back to read mode, or to bypass mode in bypass.
// - Commands open with AAh at 555h then 55h at AAAh, sector selected.
// - Only low twelve address bits take part in command decode.
// - After 90h, read at low bits 10 gives 01h protected, 00h not.
// - Program is unlock, A0h at 555h, data; data taken on strobe rise.
// - Program address taken on write strobe fall.
// - Sector erase: unlock, 80h, unlock, 30h; more sectors within 80us.
// - Bulk erase: unlock, 80h, unlock, 10h at 555h.
// - B0h at even address suspends a running sector erase.
// - 30h at even address resumes only when suspended.
// - F0h at even address returns to read mode, clears error.
// - Bypass entered by unlock plus 20h; then A0h and data program.
// - Bypass left with 90h then 00h at even addresses.
// - Read mode returns array bytes without any command cycles.
// - Plain writes never change the arrays.
// - Bit 7 reads complement of written bit while programming, 0 while erasing.
// - Bit 6 inverts on each read while busy.
module fcd_decoder
  import fcd_pkg::*;
#(
  parameter int ERASE_CYCLES = `FCD_ERASE_CYCLES
)
(
  input  wire logic        clk,
  input  wire logic        reset,
  input  wire logic [15:0] addr,
  input  wire logic [7:0]  data_in,
  input  wire logic        wr_n,
  input  wire logic        rd_n,
  input  wire logic [7:0]  primary_sector_selects,
  input  wire logic [3:0]  secondary_sector_selects,
  input  wire logic [7:0]  primary_protect,
  input  wire logic [3:0]  secondary_protect,
  output logic      [7:0]  data_out,
  output logic             data_oe,
  output logic             ready_busy_pin
);

  localparam int DEPTH = `FCD_SECTORS * `FCD_SECTOR_BYTES;

  fcd_regs_s   r;
  fcd_regs_s   next_r;
  logic [7:0]  mem [0:DEPTH-1];
  logic [11:0] sel_vec;
  logic [11:0] prot_vec;
  logic [11:0] sel_hot;
  logic [11:0] first_hot;
  logic [3:0]  sel_idx;
  logic [3:0]  erase_sec;
  logic        sel_any;
  logic        prim_hit;
  logic        w;
  logic        wr_fall;
  logic        rd_fall;
  logic        even;
  logic        is_unlock1;
  logic        is_unlock2;
  logic        at555;
  logic [11:0] a12;
  logic [7:0]  mem_rdata;
  logic [7:0]  prog_old;
  logic [7:0]  status;
  logic        busy_next;
  logic        mem_we;
  logic        erase_we;
  logic        gap_expired;
  logic        prog_load;
  logic        prog_expired;
  logic        erase_load;
  logic [15:0] erase_value;
  logic        erase_expired;

  // Lowest selected sector; select glitches with two bits high pick one
  function automatic logic [3:0] fcd_first(input logic [11:0] v);
    logic [3:0] idx;
    idx = 4'h0;
    for (int i = `FCD_SECTORS - 1; i >= 0; i--) begin
      if (v[i]) begin
        idx = 4'(i);
      end
    end
    return idx;
  endfunction

  // ****************************************************************
  // Sector routing and bus edges
  // ****************************************************************
  // Primary wins when both arrays are selected at once
  assign prim_hit  = |primary_sector_selects;
  assign sel_vec   = prim_hit ? {4'h0, primary_sector_selects}
                              : {secondary_sector_selects, 8'h00};
  assign prot_vec  = {secondary_protect, primary_protect};
  assign sel_any   = |sel_vec;
  assign sel_idx   = fcd_first(sel_vec);
  assign sel_hot   = 12'h001 << sel_idx;
  assign erase_sec = fcd_first(r.erase_mask);
  assign first_hot = 12'h001 << erase_sec;
  assign wr_fall   = r.wr_q && !wr_n;
  assign rd_fall   = r.rd_q && !rd_n;
  assign w         = !r.wr_q && wr_n && sel_any;

  // Decode fields come from the address captured at the strobe fall
  assign a12        = r.wr_addr[11:0];
  assign even       = !r.wr_addr[0];
  assign at555      = (a12 == `FCD_ADDR_UNLOCK1);
  assign is_unlock1 = at555 && data_in == `FCD_CMD_UNLOCK1;
  assign is_unlock2 = (a12 == `FCD_ADDR_UNLOCK2)
                      && data_in == `FCD_CMD_UNLOCK2;
  assign mem_rdata  = mem[{sel_idx, addr[3:0]}];
  assign prog_old   = mem[r.prog_idx];

  // ****************************************************************
  // Timers
  // ****************************************************************
  // Gap timer restarts on every decoded byte
  fcd_timer u_gap (
    .clk        (clk),
    .reset      (reset),
    .load       (w),
    .hold       (1'b0),
    .load_value (16'(`FCD_GAP_CYCLES)),
    .expired    (gap_expired)
  );

  // Program timer runs apart from the erase timer so that a program
  // can proceed inside an erase suspension
  fcd_timer u_prog (
    .clk        (clk),
    .reset      (reset),
    .load       (prog_load),
    .hold       (1'b0),
    .load_value (16'(`FCD_PROG_CYCLES)),
    .expired    (prog_expired)
  );

  // Erase timer freezes while the erase is suspended
  fcd_timer u_erase (
    .clk        (clk),
    .reset      (reset),
    .load       (erase_load),
    .hold       (r.susp),
    .load_value (erase_value),
    .expired    (erase_expired)
  );

  // ****************************************************************
  // Command decoder and sequencer
  // ****************************************************************
  always_comb begin
    next_r      = r;
    prog_load   = 1'b0;
    erase_load  = 1'b0;
    erase_value = 16'h0;
    mem_we      = 1'b0;
    erase_we    = 1'b0;
    next_r.wr_q = wr_n;
    next_r.rd_q = rd_n;
    if (wr_fall) begin
      next_r.wr_addr = addr;
    end
    case (r.state)
      ST_READ: begin
        // Other writes are ignored: arrays change only by command
        if (w && is_unlock1) begin
          next_r.state = ST_UNLK1;
          next_r.array_sel = !prim_hit;
        end else if (w && even && r.susp
                     && data_in == `FCD_CMD_RESUME) begin
          next_r.susp = 1'b0;
          next_r.state = ST_ERASE;
        end
      end
      ST_UNLK1: begin
        if (w) begin
          next_r.state = is_unlock2 ? ST_UNLK2 : ST_READ;
        end else if (gap_expired) begin
          next_r.state = ST_READ;
        end
      end
      ST_UNLK2: begin
        if (w) begin
          next_r.state = ST_READ;
          if (at555 && data_in == `FCD_CMD_PROTECT_READ) begin
            next_r.state = ST_PROT;
          end else if (at555 && data_in == `FCD_CMD_PROGRAM) begin
            next_r.state = ST_PROG_DATA;
          end else if (at555 && !r.susp
                       && data_in == `FCD_CMD_ERASE_SETUP) begin
            next_r.state = ST_ERS_CMD;
          end else if (at555 && !r.susp
                       && data_in == `FCD_CMD_BYPASS) begin
            next_r.state = ST_BYPASS;
            next_r.bypass = 1'b1;
          end
        end else if (gap_expired) begin
          next_r.state = ST_READ;
        end
      end
      ST_PROG_DATA, ST_BYP_PROG: begin
        if (w) begin
          next_r.state = r.bypass ? ST_BYPASS : ST_READ;
          // Protected or erasing sectors drop the program silently
          if (!prot_vec[sel_idx]
              && !(r.susp && r.erase_mask[sel_idx])) begin
            next_r.state = ST_PROGRAM;
            next_r.prog_idx = {sel_idx, r.wr_addr[3:0]};
            next_r.prog_data = data_in;
            prog_load = 1'b1;
          end
        end else if (gap_expired) begin
          next_r.state = r.bypass ? ST_BYPASS : ST_READ;
        end
      end
      ST_ERS_CMD: begin
        if (w) begin
          next_r.state = is_unlock1 ? ST_ERS_UNLK1 : ST_READ;
        end else if (gap_expired) begin
          next_r.state = ST_READ;
        end
      end
      ST_ERS_UNLK1: begin
        if (w) begin
          next_r.state = is_unlock2 ? ST_ERS_UNLK2 : ST_READ;
        end else if (gap_expired) begin
          next_r.state = ST_READ;
        end
      end
      ST_ERS_UNLK2: begin
        if (w && data_in == `FCD_CMD_SECTOR_ERASE) begin
          next_r.state = ST_ERS_WIN;
          next_r.erase_mask = sel_hot & ~prot_vec;
          next_r.eto = 1'b0;
          next_r.bulk = 1'b0;
          erase_load = 1'b1;
          erase_value = 16'(`FCD_ERASE_WINDOW_CYCLES);
        end else if (w && at555 && data_in == `FCD_CMD_BULK_ERASE) begin
          next_r.state = ST_ERASE;
          next_r.erase_mask = (r.array_sel ? `FCD_SECONDARY_MASK
                                           : `FCD_PRIMARY_MASK)
                              & ~prot_vec;
          next_r.eto = 1'b1;
          next_r.bulk = 1'b1;
          erase_load = 1'b1;
          erase_value = 16'(ERASE_CYCLES);
        end else if (w || gap_expired) begin
          next_r.state = ST_READ;
        end
      end
      ST_ERS_WIN: begin
        if (erase_expired) begin
          next_r.state = ST_ERASE;
          next_r.eto = 1'b1;
          erase_load = 1'b1;
          erase_value = 16'(ERASE_CYCLES);
        end else if (w && data_in == `FCD_CMD_SECTOR_ERASE) begin
          // Each added sector restarts the collection window
          next_r.erase_mask = r.erase_mask | (sel_hot & ~prot_vec);
          erase_load = 1'b1;
          erase_value = 16'(`FCD_ERASE_WINDOW_CYCLES);
        end else if (w) begin
          next_r.state = ST_READ;
          next_r.erase_mask = 12'h000;
          erase_load = 1'b1;
        end
      end
      ST_ERASE: begin
        // One sector is cleared per erase interval
        if (erase_expired) begin
          erase_we = |r.erase_mask;
          next_r.erase_mask = r.erase_mask & ~first_hot;
          if ((r.erase_mask & ~first_hot) != 12'h000) begin
            erase_load = 1'b1;
            erase_value = 16'(ERASE_CYCLES);
          end else begin
            next_r.state = ST_READ;
          end
        end else if (w && even && !r.bulk
                     && data_in == `FCD_CMD_SUSPEND) begin
          next_r.susp = 1'b1;
          next_r.state = ST_READ;
        end
      end
      ST_PROGRAM: begin
        // A zero bit cannot be raised back to one by programming
        if (prog_expired) begin
          if ((r.prog_data & ~prog_old) != 8'h00) begin
            next_r.state = ST_ERROR;
            next_r.err = 1'b1;
          end else begin
            mem_we = 1'b1;
            next_r.state = r.bypass ? ST_BYPASS : ST_READ;
          end
        end
      end
      ST_PROT, ST_ERROR: begin
        if (w && even && data_in == `FCD_CMD_RESET) begin
          next_r.state = ST_READ;
          next_r.err = 1'b0;
        end
      end
      ST_BYPASS: begin
        if (w && even && data_in == `FCD_CMD_PROGRAM) begin
          next_r.state = ST_BYP_PROG;
        end else if (w && even && data_in == `FCD_CMD_PROTECT_READ) begin
          next_r.state = ST_BYP_RST;
        end
      end
      ST_BYP_RST: begin
        if (w && even && data_in == `FCD_CMD_BYPASS_EXIT) begin
          next_r.state = ST_READ;
          next_r.bypass = 1'b0;
        end else if (w || gap_expired) begin
          next_r.state = ST_BYPASS;
        end
      end
      default: begin
        next_r.state = ST_READ;
      end
    endcase

    // Busy covers the erase collection window as well as the algorithms
    busy_next = (next_r.state == ST_PROGRAM) || (next_r.state == ST_ERASE)
                || (next_r.state == ST_ERS_WIN);
    next_r.ready_busy = !busy_next;

    // Status byte seen while an algorithm runs or after a failure
    status = 8'h00;
    status[`FCD_BIT_POLL] = (r.state == ST_PROGRAM)
                            && !r.prog_data[7];
    status[`FCD_BIT_TOGGLE] = !r.toggle;
    status[`FCD_BIT_ERROR] = r.err;
    status[`FCD_BIT_ERASE_TIMEOUT] = r.eto;

    // Read path: data latched at the read strobe fall
    next_r.data_oe = !rd_n && sel_any;
    if (rd_fall && sel_any) begin
      if ((r.state == ST_PROGRAM) || (r.state == ST_ERASE)
          || (r.state == ST_ERS_WIN)) begin
        next_r.toggle = !r.toggle;
        next_r.data_out = status;
      end else if (r.state == ST_ERROR) begin
        next_r.data_out = status;
      end else if (r.state == ST_PROT
                   && addr[1:0] == `FCD_PROT_ADDR_LOW) begin
        next_r.data_out = {7'h00, prot_vec[sel_idx]};
      end else begin
        next_r.data_out = mem_rdata;
      end
    end
  end

  // ****************************************************************
  // State register and array storage
  // ****************************************************************
  // Decoder state record
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      r <= '0;
      r.state <= ST_READ;
      r.wr_q <= 1'b1;
      r.rd_q <= 1'b1;
      r.ready_busy <= 1'b1;
    end else begin
      r <= next_r;
    end
  end

  // Arrays start erased; a whole sector clears in one cycle
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      for (int i = 0; i < DEPTH; i++) begin
        mem[i] <= `FCD_ERASED_BYTE;
      end
    end else if (erase_we) begin
      for (int i = 0; i < `FCD_SECTOR_BYTES; i++) begin
        mem[{erase_sec, 4'(i)}] <= `FCD_ERASED_BYTE;
      end
    end else if (mem_we) begin
      mem[r.prog_idx] <= r.prog_data & prog_old;
    end
  end

  assign data_out       = r.data_out;
  assign data_oe        = r.data_oe;
  assign ready_busy_pin = r.ready_busy;

endmodule

/* File: fcd_decoder_sva.sv */
/* Port checker of the flash command decoder.
   Bound to every decoder instance; sees only its ports. */
`timescale 1ns/10ps
module fcd_decoder_sva
  import fcd_pkg::*;
#(
  parameter int ERASE_CYCLES = 40000
)
(
  input wire logic        clk,
  input wire logic        reset,
  input wire logic [15:0] addr,
  input wire logic [7:0]  data_in,
  input wire logic        wr_n,
  input wire logic        rd_n,
  input wire logic [7:0]  primary_sector_selects,
  input wire logic [3:0]  secondary_sector_selects,
  input wire logic [7:0]  primary_protect,
  input wire logic [3:0]  secondary_protect,
  input wire logic [7:0]  data_out,
  input wire logic        data_oe,
  input wire logic        ready_busy_pin
);
  // Any select addresses flash
  wire logic sel = (|primary_sector_selects) || (|secondary_sector_selects);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (reset);

  // Bus drive follows the read strobe by one clock
  oe_nosel_a: assert property ($fell(rd_n) && !sel |=> !data_oe)
    else $error("unselected read drove bus");
  oe_sel_a: assert property ($fell(rd_n) && sel |=> data_oe)
    else $error("selected read not driven");
  oe_drop_a: assert property ($rose(rd_n) |=> !data_oe)
    else $error("bus held after read");
  oe_cause_a: assert property ($rose(data_oe) |-> !$past(rd_n))
    else $error("bus driven without read");
  // Read data moves only on a new read strobe
  dout_hold_a: assert property (!$fell(rd_n) |=> $stable(data_out))
    else $error("read data moved");
  // Busy begins one clock after a write strobe rise, never alone
  busy_cause_a: assert property ($fell(ready_busy_pin)
    |-> $past(wr_n) && !$past(wr_n, 2))
    else $error("busy without write");
  busy_hold_a: assert property ($fell(ready_busy_pin) |->
    !ready_busy_pin [*2])
    else $error("busy too short");
  nosel_idle_a: assert property (ready_busy_pin &&
    $rose(wr_n) && !sel |=> ready_busy_pin)
    else $error("unselected write started work");
  cover property ($fell(ready_busy_pin));
  cover property ($rose(ready_busy_pin));
  cover property ($fell(rd_n) && !ready_busy_pin);
endmodule

bind fcd_decoder fcd_decoder_sva #(.ERASE_CYCLES(ERASE_CYCLES)) sva_i (
  .clk, .reset, .addr, .data_in, .wr_n, .rd_n, .primary_sector_selects,
  .secondary_sector_selects, .primary_protect, .secondary_protect,
  .data_out, .data_oe, .ready_busy_pin);

/* File: fcd_host.sv */
/* Host bus master model: one byte write or read at a time.
   Sector selects are driven by the bench. */
`timescale 1ns/10ps
module fcd_host
  import fcd_pkg::*;
(
  input  wire logic        clk,
  input  wire logic [7:0]  data_out,
  output logic      [15:0] addr,
  output logic      [7:0]  data_in,
  output logic             wr_n,
  output logic             rd_n
);
  // Strobes idle high from time zero
  initial begin
    addr = 16'h0000;
    data_in = 8'h00;
    wr_n = 1'b1;
    rd_n = 1'b1;
  end
  // Address held from strobe fall to rise; released lines inverted
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    data_in <= d;
    wr_n <= 1'b0;
    @(posedge clk);
    wr_n <= 1'b1;
    @(posedge clk);
    addr <= ~a;
    data_in <= ~d;
  endtask
  // Answer taken after the registered output has settled
  task automatic rd(input logic [15:0] a, output logic [7:0] d);
    @(posedge clk);
    addr <= a;
    rd_n <= 1'b0;
    repeat (3) @(posedge clk);
    d = data_out;
    rd_n <= 1'b1;
    addr <= ~a;
  endtask
endmodule

/* File: testbench.sv */
/* Bench of the flash command decoder: a program, array reads from a table, then
   hand tests of commands. Erase time shortened to 200 clocks. */
`timescale 1ns/10ps
module testbench
  import fcd_pkg::*;
;
  typedef struct packed {
    logic [7:0]  ps;
    logic [3:0]  ss;
    logic [15:0] a;
    logic [7:0]  e;
  } fcd_row_s;
  logic        clk = 1'b0;
  logic        reset = 1'b1;
  logic [7:0]  ps = 8'h01;
  logic [3:0]  ss = 4'h0;
  logic [7:0]  pp = 8'h04;
  logic [3:0]  sp = 4'h0;
  logic [15:0] addr;
  logic [7:0]  din, dout, x, y;
  logic        wr_n, rd_n, oe, rb;
  int          error_cnt = 0;
  int          tests_run = 0;
  fcd_row_s    rows [5] = '{'{8'h01, 4'h0, 16'h0005, 8'h3C},
    '{8'h00, 4'h0, 16'h0004, 8'h3C}, '{8'h01, 4'h0, 16'hF004, 8'hFF},
    '{8'h02, 4'h0, 16'h0005, 8'hFF}, '{8'h00, 4'h1, 16'h0005, 8'hFF}};

  fcd_host host (.clk(clk), .data_out(dout), .addr(addr), .data_in(din),
    .wr_n(wr_n), .rd_n(rd_n));
  fcd_decoder #(.ERASE_CYCLES(200)) uut (.clk(clk), .reset(reset),
    .addr(addr), .data_in(din), .wr_n(wr_n), .rd_n(rd_n),
    .primary_sector_selects(ps), .secondary_sector_selects(ss),
    .primary_protect(pp), .secondary_protect(sp), .data_out(dout),
    .data_oe(oe), .ready_busy_pin(rb));

  // 40 MHz clock
  always #12.5 clk = ~clk;

  task automatic chk(input logic [7:0] g, input logic [7:0] e);
    tests_run++;
    if (g !== e) begin
      $display("wrong value at %0t: %h not %h", $time, g, e);
      error_cnt++;
    end
  endtask
  task automatic rd(input logic [15:0] a, input logic [7:0] e);
    host.rd(a, x);
    chk(x, e);
  endtask
  // Upper address bits vary since only the low twelve decode
  task automatic cmd(input logic [7:0] c);
    host.wr(16'hF555, 8'hAA);
    host.wr(16'h3AAA, 8'h55);
    host.wr(16'h0555, c);
  endtask
  task automatic busy(input logic v);
    repeat (2) @(posedge clk);
    chk({7'h00, rb}, {7'h00, v});
  endtask
  // Bounded wait; a hang ends the run at once
  task automatic done(input int n);
    busy(1'b0);
    for (int i = 0; i < n && rb !== 1'b1; i++) @(posedge clk);
    chk({7'h00, rb}, 8'h01);
    if (rb !== 1'b1) tally_and_finish();
  endtask
  task automatic bad(input logic [7:0] b, input int g, input logic [15:0] a);
    host.wr(16'h0555, 8'hAA);
    repeat (g) @(posedge clk);
    host.wr(16'h0AAA, b);
    host.wr(16'h0555, 8'hA0);
    host.wr(a, 8'h00);
    rd(a, 8'hFF);
  endtask
  task automatic tally_and_finish();
    $display("checks %0d errors %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  // Main sequence
  initial begin
    repeat (2) @(posedge clk);
    reset <= 1'b0;
    @(posedge clk);
    chk({oe, rb, 6'h00}, 8'h40);
    chk(dout, 8'h00);
    host.wr(16'h0005, 8'h00);
    cmd(8'hA0);
    host.wr(16'hE005, 8'h3C);
    host.rd(16'h0005, x);
    host.rd(16'h0005, y);
    chk({x[7], x[6] ^ y[6], 6'h00}, 8'hC0);
    done(500);
    foreach (rows[i]) begin
      ps <= rows[i].ps;
      ss <= rows[i].ss;
      rd(rows[i].a, rows[i].e);
    end
    ss <= 4'h0;
    host.wr(16'h0006, 8'h00);
    ps <= 8'h01;
    bad(8'h12, 0, 16'h0006);
    bad(8'h55, 2100, 16'h0007);
    cmd(8'h90);
    rd(16'h0002, 8'h00);
    ps <= 8'h04;
    rd(16'h0006, 8'h01);
    ps <= 8'h01;
    host.wr(16'h0000, 8'hF0);
    rd(16'h0002, 8'hFF);
    cmd(8'hA0);
    host.wr(16'h0005, 8'hFF);
    done(500);
    host.rd(16'h0005, x);
    chk(x & 8'h20, 8'h20);
    host.wr(16'h0000, 8'hF0);
    rd(16'h0005, 8'h3C);
    ps <= 8'h08;
    cmd(8'hA0);
    host.wr(16'h0003, 8'h5A);
    done(500);
    ps <= 8'h01;
    cmd(8'h80);
    cmd(8'h30);
    ps <= 8'h08;
    host.wr(16'h0001, 8'h30);
    ps <= 8'h01;
    repeat (3210) @(posedge clk);
    host.wr(16'h0000, 8'hB0);
    busy(1'b1);
    ps <= 8'h02;
    cmd(8'hA0);
    host.wr(16'h0003, 8'h11);
    done(500);
    rd(16'h0003, 8'h11);
    ps <= 8'h01;
    host.wr(16'h0000, 8'h30);
    done(500);
    rd(16'h0005, 8'hFF);
    ps <= 8'h08;
    rd(16'h0003, 8'hFF);
    cmd(8'h80);
    cmd(8'h10);
    host.wr(16'h0000, 8'hB0);
    done(2000);
    ps <= 8'h02;
    rd(16'h0003, 8'hFF);
    cmd(8'h20);
    host.wr(16'h0002, 8'hA0);
    host.wr(16'h0008, 8'h77);
    done(500);
    host.wr(16'h0000, 8'h90);
    host.wr(16'h0000, 8'h00);
    rd(16'h0008, 8'h77);
    host.wr(16'h0002, 8'hA0);
    host.wr(16'h0009, 8'h00);
    rd(16'h0009, 8'hFF);
    // Mid-run reset: arrays back to erased, ready high
    reset <= 1'b1;
    repeat (2) @(posedge clk);
    reset <= 1'b0;
    @(posedge clk);
    chk({oe, rb, 6'h00}, 8'h40);
    rd(16'h0008, 8'hFF);
    tally_and_finish();
  end
endmodule
